/* File: core/epx_params.svh */
// constants of the exception priority and partial execution unit
`ifndef EPX_PARAMS_SVH
`define EPX_PARAMS_SVH

`define EPX_FP_IGNORED      2'b00
`define EPX_FP_IMP_NONREC   2'b01
`define EPX_FP_IMP_REC      2'b10
`define EPX_FP_PRECISE      2'b11
`define EPX_TAG_W           6
`define EPX_REG_W           5
`define EPX_MASK_W          32
`define EPX_CAUSE_W         3
`define EPX_CAUSE_NONE      3'h0
`define EPX_CAUSE_RESET     3'h1
`define EPX_CAUSE_MCHECK    3'h2
`define EPX_CAUSE_PRECISE   3'h3
`define EPX_CAUSE_IMPREC    3'h4
`define EPX_CAUSE_EXT       3'h5
`define EPX_CAUSE_DEC       3'h6

`endif

/* File: core/epx_pkg.sv */
// types of the exception priority and partial execution unit
package epx_pkg;
    typedef enum logic [1:0] {
        EPX_FP_OFF,
        EPX_FP_NONREC,
        EPX_FP_REC,
        EPX_FP_PREC
    } epx_fp_mode_t;

    typedef enum logic [2:0] {
        EPX_OP_INT_LOAD,
        EPX_OP_LOAD_MULTI,
        EPX_OP_STORE_MULTI,
        EPX_OP_STORE,
        EPX_OP_STORE_COND,
        EPX_OP_FP_LOAD,
        EPX_OP_OTHER
    } epx_op_t;

    typedef enum logic {
        EPX_RUN,
        EPX_STOPPED
    } epx_state_t;
endpackage

/* File: core/epx_abort_gate.sv */
// write gating for loads and stores aborted by alignment or storage faults
`timescale 1ns/1ps
`include "epx_params.svh"

module epx_abort_gate
    import epx_pkg::*;
(
    // access being completed
    input  wire epx_pkg::epx_op_t op_i,
    input  wire logic             is_update_i,
    input  wire logic             aborted_i,
    input  wire logic             protect_ok_i,
    input  wire logic             wr_dest_req_i,
    input  wire logic             wr_mem_req_i,
    input  wire logic             wr_base_req_i,
    input  wire logic             wr_cond_req_i,
    // permitted writes
    output logic                  wr_dest_o,
    output logic                  wr_mem_o,
    output logic                  wr_base_o,
    output logic                  wr_cond_o,
    output logic                  cond_undef_o
);
    always_comb
    begin
        wr_dest_o    = wr_dest_req_i & protect_ok_i;
        wr_mem_o     = wr_mem_req_i & protect_ok_i;
        wr_base_o    = wr_base_req_i & is_update_i;
        wr_cond_o    = wr_cond_req_i;
        cond_undef_o = 1'b0;
        if (aborted_i)
        begin
            // base update never lands on an aborted access
            wr_base_o = 1'b0;
            wr_cond_o = 1'b0;
            case (op_i)
                EPX_OP_INT_LOAD:
                begin
                    wr_dest_o = 1'b0;
                    wr_mem_o  = 1'b0;
                end
                EPX_OP_LOAD_MULTI:
                    wr_mem_o  = 1'b0;
                EPX_OP_STORE_MULTI:
                    wr_dest_o = 1'b0;
                EPX_OP_STORE:
                    wr_dest_o = 1'b0;
                EPX_OP_STORE_COND:
                begin
                    wr_dest_o    = 1'b0;
                    cond_undef_o = 1'b1;
                end
                EPX_OP_FP_LOAD:
                    wr_mem_o  = 1'b0;
                default:
                begin
                    wr_dest_o = 1'b0;
                    wr_mem_o  = 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: core/epx_unit.sv */
// exception priority selection and floating-point enabled mode control
`timescale 1ns/1ps
`include "epx_params.svh"

// Notes on behaviour
// - two mode bits pick fp exception handling
// - nonrecoverable: late entry, offender may be unknown
// - recoverable: later instructions never see bad data
// - recoverable: handler gets offender tag and register
// - aborted load multiple may load some registers
// - aborted store multiple may write some bytes
// - aborted store: bytes maybe, base never updated
// - aborted store conditional leaves condition undefined
// - aborted fp load may write target, not base
// - partial writes never break memory protection
// - aborted integer loads write nothing at all
// - reset and machine check never wait
// - machine check while disabled enters checkstop
// - precise exceptions taken in program order
// - pending imprecise blocks later instruction state
// - imprecise pending gives program unless async high
// - external and decrementer get lowest priority
// - reset is priority one, ignores others
// - machine check is priority two
// - precise waits for older instructions first
// - imprecise fp is priority three
module epx_unit
    import epx_pkg::*;
#(
    parameter int TAG_W = `EPX_TAG_W,
    parameter int REG_W = `EPX_REG_W
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // machine state word fields
    input  wire logic             fp_mode_hi_i,
    input  wire logic             fp_mode_lo_i,
    input  wire logic             ext_enable_i,
    input  wire logic             mcheck_enable_i,
    // asynchronous sources
    input  wire logic             sys_reset_req_i,
    input  wire logic             mcheck_req_i,
    input  wire logic             ext_int_req_i,
    input  wire logic             dec_req_i,
    // oldest instruction at completion
    input  wire logic             cmp_valid_i,
    input  wire logic [TAG_W-1:0] cmp_tag_i,
    input  wire logic             cmp_older_done_i,
    input  wire logic             cmp_precise_exc_i,
    input  wire logic             cmp_fp_exc_i,
    input  wire logic [REG_W-1:0] cmp_fp_dest_i,
    input  wire epx_pkg::epx_op_t cmp_op_i,
    input  wire logic             cmp_is_update_i,
    input  wire logic             cmp_aborted_i,
    input  wire logic             cmp_protect_ok_i,
    input  wire logic             cmp_wr_dest_i,
    input  wire logic             cmp_wr_mem_i,
    input  wire logic             cmp_wr_base_i,
    input  wire logic             cmp_wr_cond_i,
    // handler hand-off
    input  wire logic             handler_ack_i,
    // write permits to the pipeline
    output logic                  wr_dest_o,
    output logic                  wr_mem_o,
    output logic                  wr_base_o,
    output logic                  wr_cond_o,
    output logic                  cond_undef_o,
    output logic                  cmp_stall_o,
    output logic                  fp_fwd_block_o,
    // handler entry
    output logic                  take_o,
    output logic [`EPX_CAUSE_W-1:0] cause_o,
    output logic [TAG_W-1:0]      fault_tag_o,
    output logic [REG_W-1:0]      fault_reg_o,
    output logic                  fault_known_o,
    output logic                  checkstop_o,
    output logic [1:0]            fp_mode_o
);
    typedef struct packed {
        epx_state_t              state;
        logic                    take;
        logic [`EPX_CAUSE_W-1:0] cause;
        logic [TAG_W-1:0]        tag;
        logic [REG_W-1:0]        freg;
        logic                    known;
        logic                    imp_pend;
        logic [TAG_W-1:0]        imp_tag;
        logic [REG_W-1:0]        imp_reg;
        logic                    imp_known;
        logic                    rst_pend;
        logic                    mck_pend;
        logic                    ext_pend;
        logic                    dec_pend;
    } epx_unit_state_t;

    epx_unit_state_t r;
    epx_unit_state_t next_r;

    logic [1:0]   mode;
    logic         fp_raise;
    logic         prec_raise;
    logic         gate_open;
    logic         imp_new;
    logic         blocked;
    logic         dest_ok;
    logic         mem_ok;
    logic         base_ok;
    logic         cond_ok;
    logic         cond_undef;

    // mode select from the two machine state bits
    function automatic epx_fp_mode_t fp_mode_of(input logic [1:0] m);
        case (m)
            `EPX_FP_IGNORED:    fp_mode_of = EPX_FP_OFF;
            `EPX_FP_IMP_NONREC: fp_mode_of = EPX_FP_NONREC;
            `EPX_FP_IMP_REC:    fp_mode_of = EPX_FP_REC;
            default:            fp_mode_of = EPX_FP_PREC;
        endcase
    endfunction

    assign mode = {fp_mode_hi_i, fp_mode_lo_i};

    // an instruction flagged cmp_aborted_i behaves as aborted for writes
    epx_abort_gate u_gate (
        .op_i          (cmp_op_i),
        .is_update_i   (cmp_is_update_i),
        .aborted_i     (cmp_aborted_i),
        .protect_ok_i  (cmp_protect_ok_i),
        .wr_dest_req_i (cmp_wr_dest_i),
        .wr_mem_req_i  (cmp_wr_mem_i),
        .wr_base_req_i (cmp_wr_base_i),
        .wr_cond_req_i (cmp_wr_cond_i),
        .wr_dest_o     (dest_ok),
        .wr_mem_o      (mem_ok),
        .wr_base_o     (base_ok),
        .wr_cond_o     (cond_ok),
        .cond_undef_o  (cond_undef)
    );

    always_comb
    begin
        // ignored mode drops the fp condition entirely
        fp_raise   = cmp_valid_i & cmp_fp_exc_i &
                     (fp_mode_of(mode) != EPX_FP_OFF);
        // precise exceptions only once every older instruction is done
        prec_raise = cmp_valid_i & cmp_older_done_i &
                     (cmp_precise_exc_i |
                      (fp_raise &
                       fp_mode_of(mode) == EPX_FP_PREC));
        blocked    = r.imp_pend | r.take | (r.state == EPX_STOPPED) |
                     r.rst_pend | r.mck_pend;
        // later instructions may not touch state behind an imprecise one
        gate_open  = cmp_valid_i & ~blocked & ~prec_raise;
        // an fp fault in an imprecise mode is parked, not taken at once
        imp_new    = fp_raise & (fp_mode_of(mode) != EPX_FP_PREC) &
                     ~r.imp_pend & gate_open;
    end

    always_comb
    begin
        wr_dest_o    = gate_open & dest_ok;
        wr_mem_o     = gate_open & mem_ok;
        wr_base_o    = gate_open & base_ok;
        wr_cond_o    = gate_open & cond_ok;
        cond_undef_o = gate_open & cond_undef;
        // recoverable mode holds the fp result back from consumers
        fp_fwd_block_o = fp_raise &
                         (fp_mode_of(mode) != EPX_FP_NONREC);
        cmp_stall_o  = cmp_valid_i & (blocked | ~cmp_older_done_i);
    end

    always_comb
    begin
        next_r = r;
        // the ack retires the entry; a new winner may follow next cycle
        if (r.take && handler_ack_i)
            next_r.take = 1'b0;
        // asynchronous requests are latched, so a loser stays pending, except a machine check, which reset clears
        next_r.rst_pend = r.rst_pend | sys_reset_req_i;
        next_r.mck_pend = r.mck_pend | mcheck_req_i;
        next_r.ext_pend = ext_int_req_i | dec_req_i ?
                          r.ext_pend | ext_int_req_i : r.ext_pend;
        next_r.dec_pend = r.dec_pend | dec_req_i;
        if (ext_int_req_i == 1'b0)
            next_r.ext_pend = r.ext_pend;
        if (imp_new)
        begin
            next_r.imp_pend  = 1'b1;
            next_r.imp_tag   = cmp_tag_i;
            next_r.imp_reg   = cmp_fp_dest_i;
            // nonrecoverable mode need not name the offender
            next_r.imp_known = (fp_mode_of(mode) == EPX_FP_REC);
        end
        case (r.state)
            EPX_RUN:
            begin
                // reset and machine check preempt even an unacked entry
                if (next_r.rst_pend)
                begin
                    next_r.take     = 1'b1;
                    next_r.cause    = `EPX_CAUSE_RESET;
                    next_r.rst_pend = 1'b0;
                    next_r.mck_pend = 1'b0;
                    next_r.imp_pend = 1'b0;
                    next_r.known    = 1'b0;
                end
                else if (next_r.mck_pend)
                begin
                    next_r.mck_pend = 1'b0;
                    if (!mcheck_enable_i)
                    begin
                        next_r.state = EPX_STOPPED;
                        next_r.take  = 1'b0;
                    end
                    else
                    begin
                        // overwrites an unacked entry; the core replays it
                        next_r.take  = 1'b1;
                        next_r.cause = `EPX_CAUSE_MCHECK;
                        next_r.known = 1'b0;
                    end
                end
                else if (!r.take)
                begin
                    if (r.imp_pend)
                    begin
                        next_r.take     = 1'b1;
                        next_r.cause    = `EPX_CAUSE_IMPREC;
                        next_r.tag      = r.imp_tag;
                        next_r.freg     = r.imp_reg;
                        next_r.known    = r.imp_known;
                        next_r.imp_pend = 1'b0;
                    end
                    else if (prec_raise && !blocked)
                    begin
                        next_r.take  = 1'b1;
                        next_r.cause = `EPX_CAUSE_PRECISE;
                        next_r.tag   = cmp_tag_i;
                        next_r.freg  = cmp_fp_dest_i;
                        next_r.known = 1'b1;
                    end
                    // a fault parked this cycle outranks both maskable ones
                    else if (ext_enable_i && r.ext_pend &&
                             !imp_new)
                    begin
                        next_r.take     = 1'b1;
                        next_r.cause    = `EPX_CAUSE_EXT;
                        next_r.known    = 1'b0;
                        next_r.ext_pend = ext_int_req_i;
                    end
                    else if (ext_enable_i && r.dec_pend &&
                             !imp_new)
                    begin
                        next_r.take     = 1'b1;
                        next_r.cause    = `EPX_CAUSE_DEC;
                        next_r.known    = 1'b0;
                        next_r.dec_pend = dec_req_i;
                    end
                end
            end
            EPX_STOPPED:
            begin
                // only a system reset leaves checkstop
                next_r.take = 1'b0;
                if (next_r.rst_pend)
                begin
                    next_r.state    = EPX_RUN;
                    next_r.take     = 1'b1;
                    next_r.cause    = `EPX_CAUSE_RESET;
                    next_r.rst_pend = 1'b0;
                    next_r.mck_pend = 1'b0;
                    next_r.imp_pend = 1'b0;
                    next_r.known    = 1'b0;
                end
            end
            default:
                next_r.state = EPX_RUN;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            r       <= '0;
            r.state <= EPX_RUN;
        end
        else
            r <= next_r;
    end

    assign take_o        = r.take;
    // between entries the cause reads none, never a stale code
    assign cause_o       = r.take ? r.cause : `EPX_CAUSE_NONE;
    assign fault_tag_o   = r.tag;
    assign fault_reg_o   = r.freg;
    assign fault_known_o = r.known;
    assign checkstop_o   = (r.state == EPX_STOPPED);
    assign fp_mode_o     = mode;
endmodule

/* File: verif/epx_unit_sva.sv */
// concurrent checks on the exception unit's ports
`timescale 1ns/1ps
`include "epx_params.svh"

module epx_unit_chk
    import epx_pkg::*;
#(
    parameter int TAG_W = `EPX_TAG_W
)
(
    // clock and reset
    input wire logic                   clk_i,
    input wire logic                   srst_i,
    // inputs the checks depend on
    input wire logic                   mcheck_enable_i,
    input wire logic                   sys_reset_req_i,
    input wire logic                   mcheck_req_i,
    input wire logic                   cmp_valid_i,
    input wire logic [TAG_W-1:0]       cmp_tag_i,
    input wire logic                   cmp_older_done_i,
    input wire logic                   cmp_precise_exc_i,
    input wire logic                   cmp_fp_exc_i,
    input wire epx_pkg::epx_op_t       cmp_op_i,
    input wire logic                   cmp_aborted_i,
    // outputs under check
    input wire logic                   wr_dest_o,
    input wire logic                   wr_mem_o,
    input wire logic                   wr_base_o,
    input wire logic                   wr_cond_o,
    input wire logic                   cmp_stall_o,
    input wire logic                   take_o,
    input wire logic [`EPX_CAUSE_W-1:0] cause_o,
    input wire logic [TAG_W-1:0]       fault_tag_o,
    input wire logic                   fault_known_o,
    input wire logic                   checkstop_o,
    input wire logic [1:0]             fp_mode_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    AST_RST_FIRST: assert property (
        sys_reset_req_i |=> take_o && cause_o == `EPX_CAUSE_RESET)
        else $error("reset request not taken next cycle");
    AST_MCK_NEXT: assert property (
        mcheck_req_i && mcheck_enable_i && !sys_reset_req_i && !checkstop_o
        && !(take_o && cause_o == `EPX_CAUSE_RESET)
        |=> take_o && cause_o == `EPX_CAUSE_MCHECK)
        else $error("machine check not taken next cycle");
    AST_CHKSTOP_SET: assert property (
        mcheck_req_i && !mcheck_enable_i && !sys_reset_req_i
        |=> checkstop_o && !take_o)
        else $error("disabled machine check did not stop");
    AST_PRECISE: assert property (
        cmp_valid_i && cmp_older_done_i && cmp_precise_exc_i && !cmp_fp_exc_i
        && !cmp_stall_o && !sys_reset_req_i && !mcheck_req_i
        |=> take_o && cause_o == `EPX_CAUSE_PRECISE
        && fault_tag_o == $past(cmp_tag_i))
        else $error("precise exception not entered");
    AST_IMP_ENTRY: assert property (
        cmp_valid_i && cmp_older_done_i && cmp_fp_exc_i && !cmp_precise_exc_i
        && fp_mode_o == 2'h2 && !cmp_stall_o && !sys_reset_req_i
        && !mcheck_req_i ##1 cmp_valid_i && !sys_reset_req_i && !mcheck_req_i
        |-> cmp_stall_o ##1 (take_o && cause_o == `EPX_CAUSE_IMPREC
        && fault_known_o && fault_tag_o == $past(cmp_tag_i, 2)))
        else $error("recoverable entry wrong");
    AST_FP_OFF: assert property (
        cmp_valid_i && cmp_fp_exc_i && fp_mode_o == 2'h0 && !cmp_stall_o
        |=> ##1 !(take_o && cause_o == `EPX_CAUSE_IMPREC))
        else $error("ignored mode raised fp exception");
    AST_INT_LOAD: assert property (
        cmp_aborted_i && cmp_op_i == EPX_OP_INT_LOAD
        |-> !wr_dest_o && !wr_mem_o && !wr_base_o)
        else $error("aborted integer load wrote state");
    AST_NO_BASE: assert property (
        cmp_aborted_i |-> !wr_base_o && !wr_cond_o)
        else $error("aborted access updated base or condition");
endmodule

/* File: verif/epx_ack_model.sv */
// handler-side stand-in that acknowledges each handler entry
`timescale 1ns/1ps

module epx_ack_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // entry seen and answer delay in cycles
    input  wire logic       take_i,
    input  wire logic [3:0] delay_i,
    // one-cycle acknowledge
    output logic            ack_o
);
    logic [3:0] cnt;

    // >= so a delay lowered mid-wait cannot leave entry unanswered
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !take_i || ack_o)
        begin
            cnt   <= 4'h0;
            ack_o <= 1'h0;
        end
        else if (cnt >= delay_i)
            ack_o <= 1'h1;
        else
            cnt <= cnt + 4'h1;
    end
endmodule

/* File: verif/epx_unit_test.sv */
// self-checking bench of the exception priority unit
`timescale 1ns/1ps
`include "epx_params.svh"

module epx_unit_test;
    import epx_pkg::*;
    logic clk_i, srst_i, fp_mode_hi_i, fp_mode_lo_i, ext_enable_i;
    logic mcheck_enable_i, sys_reset_req_i, mcheck_req_i, ext_int_req_i;
    logic dec_req_i, cmp_valid_i, cmp_older_done_i, cmp_precise_exc_i;
    logic cmp_fp_exc_i, cmp_is_update_i, cmp_aborted_i, cmp_protect_ok_i;
    logic cmp_wr_dest_i, cmp_wr_mem_i, cmp_wr_base_i, cmp_wr_cond_i;
    logic handler_ack_i, wr_dest_o, wr_mem_o, wr_base_o, wr_cond_o;
    logic cond_undef_o, cmp_stall_o, fp_fwd_block_o, take_o;
    logic fault_known_o, checkstop_o;
    logic [5:0] cmp_tag_i, fault_tag_o;
    logic [4:0] cmp_fp_dest_i, fault_reg_o;
    logic [2:0] cause_o;
    logic [1:0] fp_mode_o;
    logic [3:0] ack_dly;
    epx_op_t    cmp_op_i;
    int         fails, total_checks;

    epx_unit uut (.*);
    epx_ack_model ack_m (.clk_i(clk_i), .srst_i(srst_i), .take_i(take_o),
        .delay_i(ack_dly), .ack_o(handler_ack_i));

    initial
    begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic end_sim();
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, g);
        chk(n, {7'h0, e}, {7'h0, g});
    endtask
    task automatic nx();
        @(negedge clk_i);
    endtask
    task automatic clr();
        {sys_reset_req_i, mcheck_req_i, ext_int_req_i, dec_req_i} = 4'h0;
        {cmp_valid_i, cmp_precise_exc_i, cmp_fp_exc_i} = 3'h0;
    endtask
    task automatic pres(input logic [5:0] t, input logic p, f);
        {cmp_valid_i, cmp_older_done_i} = 2'h3;
        cmp_tag_i = t;
        cmp_precise_exc_i = p;
        cmp_fp_exc_i = f;
    endtask
    task automatic seen(input logic [2:0] c);
        nx();
        chk("take_cause", {4'h0, 1'h1, c}, {4'h0, take_o, cause_o});
        clr();
    endtask
    // polls each cycle: a later entry may follow an ack back to back
    task automatic await(input logic [2:0] c);
        for (int i = 0; i < 40 && !(take_o && cause_o == c); i++)
            nx();
        chk("take_cause", {4'h0, 1'h1, c}, {4'h0, take_o, cause_o});
    endtask
    task automatic drain();
        for (int i = 0; i < 40 && take_o !== 1'h0; i++)
            nx();
        chkb("take_o", 1'h0, take_o);
    endtask
    task automatic op(input epx_op_t o);
        nx();
        cmp_op_i = o;
        #1;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk_i);
        fails++;
        end_sim();
    end

    initial
    begin
        {fails, total_checks} = 64'h0;
        {ack_dly, srst_i, cmp_older_done_i, cmp_aborted_i} = 7'h24;
        clr();
        {fp_mode_hi_i, fp_mode_lo_i, ext_enable_i, mcheck_enable_i} = 4'h3;
        {cmp_protect_ok_i, cmp_is_update_i, cmp_wr_dest_i} = 3'h7;
        {cmp_wr_mem_i, cmp_wr_base_i, cmp_wr_cond_i} = 3'h7;
        {cmp_tag_i, cmp_fp_dest_i} = {6'h0, 5'h0b};
        cmp_op_i = EPX_OP_OTHER;
        repeat (5) @(posedge clk_i);
        nx();
        srst_i = 1'h0;
        chk("rst", 8'h0, {3'h0, checkstop_o, take_o, cause_o});
        for (int m = 0; m < 4; m++)
        begin
            nx();
            {fp_mode_hi_i, fp_mode_lo_i} = m[1:0];
            #1;
            chk("fp_mode_o", 8'(m), {6'h0, fp_mode_o});
        end
        {fp_mode_hi_i, fp_mode_lo_i} = 2'h0;
        mcheck_req_i = 1'h1;
        seen(`EPX_CAUSE_MCHECK);
        drain();
        sys_reset_req_i = 1'h1;
        pres(6'h05, 1'h1, 1'h0);
        seen(`EPX_CAUSE_RESET);
        drain();
        ack_dly = 4'h8;
        pres(6'h15, 1'h1, 1'h0);
        seen(`EPX_CAUSE_PRECISE);
        chk("fault_tag_o", 8'h15, {2'h0, fault_tag_o});
        pres(6'h2a, 1'h1, 1'h0);
        #1;
        chkb("cmp_stall_o", 1'h1, cmp_stall_o);
        mcheck_req_i = 1'h1;
        seen(`EPX_CAUSE_MCHECK);
        ack_dly = 4'h2;
        drain();
        pres(6'h2a, 1'h1, 1'h0);
        cmp_older_done_i = 1'h0;
        nx();
        nx();
        chkb("take_o", 1'h0, take_o);
        cmp_older_done_i = 1'h1;
        seen(`EPX_CAUSE_PRECISE);
        chk("fault_tag_o", 8'h2a, {2'h0, fault_tag_o});
        drain();
        {fp_mode_hi_i, fp_mode_lo_i} = 2'h2;
        pres(6'h21, 1'h0, 1'h1);
        #1;
        chkb("fp_fwd_block_o", 1'h1, fp_fwd_block_o);
        nx();
        pres(6'h22, 1'h1, 1'h0);
        #1;
        chkb("cmp_stall_o", 1'h1, cmp_stall_o);
        chkb("wr_dest_o", 1'h0, wr_dest_o);
        seen(`EPX_CAUSE_IMPREC);
        chkb("fault_known_o", 1'h1, fault_known_o);
        chk("fault_tag_o", 8'h21, {2'h0, fault_tag_o});
        chk("fault_reg_o", 8'h0b, {3'h0, fault_reg_o});
        drain();
        {fp_mode_hi_i, fp_mode_lo_i} = 2'h1;
        pres(6'h23, 1'h0, 1'h1);
        #1;
        chkb("fp_fwd_block_o", 1'h0, fp_fwd_block_o);
        nx();
        clr();
        mcheck_req_i = 1'h1;
        seen(`EPX_CAUSE_MCHECK);
        await(`EPX_CAUSE_IMPREC);
        chkb("fault_known_o", 1'h0, fault_known_o);
        drain();
        {fp_mode_hi_i, fp_mode_lo_i, ext_enable_i} = 3'h0;
        pres(6'h24, 1'h0, 1'h1);
        {ext_int_req_i, dec_req_i} = 2'h3;
        nx();
        clr();
        nx();
        nx();
        chkb("take_o", 1'h0, take_o);
        ext_enable_i = 1'h1;
        pres(6'h30, 1'h1, 1'h0);
        seen(`EPX_CAUSE_PRECISE);
        await(`EPX_CAUSE_EXT);
        nx();
        await(`EPX_CAUSE_DEC);
        drain();
        pres(6'h31, 1'h0, 1'h0);
        cmp_aborted_i = 1'h1;
        for (int k = 0; k < 7; k++)
        begin
            op(epx_op_t'(k));
            chkb("wr_base_o", 1'h0, wr_base_o);
            chkb("wr_cond_o", 1'h0, wr_cond_o);
        end
        op(EPX_OP_INT_LOAD);
        chk("int_load", 8'h0, {6'h0, wr_dest_o, wr_mem_o});
        op(EPX_OP_LOAD_MULTI);
        chkb("wr_dest_o", 1'h1, wr_dest_o);
        op(EPX_OP_STORE_MULTI);
        chkb("wr_mem_o", 1'h1, wr_mem_o);
        op(EPX_OP_STORE);
        chkb("wr_mem_o", 1'h1, wr_mem_o);
        op(EPX_OP_STORE_COND);
        chkb("cond_undef_o", 1'h1, cond_undef_o);
        op(EPX_OP_FP_LOAD);
        chkb("wr_dest_o", 1'h1, wr_dest_o);
        cmp_protect_ok_i = 1'h0;
        op(EPX_OP_STORE_MULTI);
        chkb("wr_mem_o", 1'h0, wr_mem_o);
        {cmp_protect_ok_i, cmp_aborted_i} = 2'h2;
        op(EPX_OP_STORE);
        chkb("wr_base_o", 1'h1, wr_base_o);
        clr();
        mcheck_enable_i = 1'h0;
        mcheck_req_i = 1'h1;
        nx();
        clr();
        nx();
        chk("stop", 8'h1, {6'h0, take_o, checkstop_o});
        sys_reset_req_i = 1'h1;
        seen(`EPX_CAUSE_RESET);
        chkb("checkstop_o", 1'h0, checkstop_o);
        mcheck_enable_i = 1'h1;
        drain();
        end_sim();
    end
endmodule

bind epx_unit epx_unit_chk #(.TAG_W(TAG_W)) sva_i (.*);
